// File: lpsc_addr_ptr.sv
// auto-incrementing internal address pointer
`timescale 1ns/1ps
module lpsc_addr_ptr #(
   parameter int W = 8
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic load,
   input wire logic [W-1:0] load_val,
   input wire logic step,
   output logic [W-1:0] ptr_ff
);
   logic [W-1:0] nxt_ptr;

   always_comb begin
      nxt_ptr = ptr_ff;
      if (load) begin
         nxt_ptr = load_val;
      end else if (step) begin
         nxt_ptr = ptr_ff + {{(W-1){1'b0}}, 1'b1};
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ptr_ff <= '0;
      end else begin
         ptr_ff <= nxt_ptr;
      end
   end
endmodule // lpsc_addr_ptr

// File: lpsc_host_model.sv
// host model: command, pointer and data byte strobes after the power-up quiet time
`timescale 1ns/1ps
module lpsc_host_model #(
   parameter int QUIET_CYC = 20
) (
   input wire logic clk,
   input wire logic reset_n,
   output logic cmd_valid,
   output logic [7:0] cmd_byte,
   output logic ptr_load,
   output logic [7:0] ptr_value,
   output logic data_strobe,
   output logic data_write
);
   int quiet_cnt = 0;

   initial begin
      cmd_valid = 1'b0;
      cmd_byte = 8'h00;
      ptr_load = 1'b0;
      ptr_value = 8'h00;
      data_strobe = 1'b0;
      data_write = 1'b0;
   end

   always @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         quiet_cnt <= 0;
      end else if (quiet_cnt < QUIET_CYC) begin
         quiet_cnt <= quiet_cnt + 1;
      end
   end

   // kind 0 command, 1 pointer load, 2 data byte (v[0] = write)
   task automatic xfer(input int kind, input logic [7:0] v);
      while (!reset_n || quiet_cnt < QUIET_CYC) begin
         @(posedge clk);
         #1;
      end
      cmd_byte = v;
      ptr_value = v;
      data_write = v[0];
      cmd_valid = (kind == 0);
      ptr_load = (kind == 1);
      data_strobe = (kind == 2);
      @(posedge clk);
      #1;
      cmd_valid = 1'b0;
      ptr_load = 1'b0;
      data_strobe = 1'b0;
      // released lines must not keep showing the old byte
      cmd_byte = ~v;
      ptr_value = ~v;
      data_write = ~v[0];
      @(posedge clk);
      #1;
   endtask
endmodule // lpsc_host_model

// File: lpsc_pkg.sv
// constants and types for the led driver power and standby control
package lpsc_pkg;
   localparam int NUM_ANODE = 12;
   localparam int NUM_CATH = 8;
   localparam int INT_PIN_IDX = 11;
   localparam int STRAP0_IDX = 1;
   localparam int STRAP1_IDX = 0;
   localparam int KEY_COL_LO = 2;
   localparam logic [7:0] CMD_MASK = 8'hf0;
   localparam logic [7:0] CMD_SYS = 8'h20;
   localparam logic [7:0] CMD_DISP = 8'h80;
   localparam logic [7:0] CMD_PIN = 8'ha0;
   localparam logic [7:0] CMD_DIM = 8'he0;
   localparam logic [7:0] SLAVE_BASE = 8'he0;
   localparam logic [3:0] RST_BRIGHT = 4'hf;
   localparam logic [1:0] RST_PIN_CFG = 2'h0;
   localparam logic [1:0] RST_BLINK = 2'h0;
   localparam logic [7:0] RST_CATH_O = 8'h0f;
   localparam logic [7:0] RST_CATH_OE = 8'h0f;
   localparam int CLK_HZ = 100_000_000;
   localparam int POR_QUIET_MS = 1;
   localparam int POR_QUIET_CYC = POR_QUIET_MS * (CLK_HZ / 1000);
   localparam int SCAN_CYCLE_MS = 20;
   localparam int SCAN_CYCLE_CYC = SCAN_CYCLE_MS * (CLK_HZ / 1000);
   localparam int SCAN_STEP_US = 100;
   localparam int SCAN_STEP_CYC = SCAN_STEP_US * (CLK_HZ / 1_000_000);
   typedef enum logic [2:0] {
      ST_STANDBY = 3'b001,
      ST_WAKE = 3'b010,
      ST_RUN = 3'b100
   } lpsc_state_t;
   typedef enum logic [4:0] {
      PH_STRAP = 5'b00001,
      PH_ROW0 = 5'b00010,
      PH_ROW1 = 5'b00100,
      PH_ROW2 = 5'b01000,
      PH_DISP = 5'b10000
   } lpsc_phase_t;
endpackage

// File: lpsc_power_ctrl.sv
// power-on, standby and wake-up control with pin roles of the led driver
`timescale 1ns/1ps
module lpsc_power_ctrl #(
   parameter int STEP_CYC = lpsc_pkg::SCAN_STEP_CYC,
   parameter int CYCLE_CYC = lpsc_pkg::SCAN_CYCLE_CYC
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic cmd_valid,
   input wire logic [7:0] cmd_byte,
   input wire logic ptr_load,
   input wire logic [7:0] ptr_value,
   input wire logic data_strobe,
   input wire logic data_write,
   input wire logic key_wake,
   input wire logic key_int_flag,
   input wire logic [11:0] disp_anode,
   input wire logic [2:0] disp_row,
   input wire logic [11:0] anode_line_i,
   output logic osc_run_ff,
   output logic display_on_ff,
   output logic key_scan_run_ff,
   output logic key_clear_ff,
   output logic [1:0] blink_ff,
   output logic [3:0] brightness_ff,
   output logic [1:0] shared_pin_config_ff,
   output logic [7:0] slave_addr_ff,
   output logic cmd_accept_ff,
   output logic ram_we_ff,
   output logic [7:0] ram_addr_ff,
   output logic [7:0] cathode_line_o_ff,
   output logic [7:0] cathode_line_oe_ff,
   output logic [11:0] anode_line_o_ff,
   output logic [11:0] anode_line_oe_ff,
   output logic [11:0] anode_pulldown_ff
);
   lpsc_pkg::lpsc_state_t state_ff;
   lpsc_pkg::lpsc_state_t nxt_state;
   lpsc_pkg::lpsc_phase_t phase_ff;
   logic strap_last_ff;
   logic scan_done_ff;
   logic disp_cfg_ff;
   logic por_sample_ff;
   logic nxt_disp_cfg;
   logic nxt_por_sample;
   logic [1:0] nxt_blink;
   logic [3:0] nxt_bright;
   logic [1:0] nxt_pin_cfg;
   logic [7:0] nxt_slave;
   logic nxt_accept;
   logic nxt_we;
   logic [7:0] nxt_cath_o;
   logic [7:0] nxt_cath_oe;
   logic [11:0] nxt_an_o;
   logic [11:0] nxt_an_oe;
   logic [11:0] nxt_pd;
   logic is_sys;
   logic cmd_ok;
   logic standby;
   logic int_level;
   logic [11:0] key_cols;

   assign is_sys = (cmd_byte & lpsc_pkg::CMD_MASK) == lpsc_pkg::CMD_SYS;
   assign standby = state_ff == lpsc_pkg::ST_STANDBY;
   // only the system set command gets through while asleep
   assign cmd_ok = cmd_valid && (!standby || is_sys);
   assign key_cols = {{(lpsc_pkg::NUM_ANODE - lpsc_pkg::KEY_COL_LO){1'b1}}, {lpsc_pkg::KEY_COL_LO{1'b0}}};

   lpsc_scan_seq #(
      .STEP_CYC(STEP_CYC),
      .CYCLE_CYC(CYCLE_CYC)
   ) u_scan (
      .clk(clk),
      .reset_n(reset_n),
      .run(!standby),
      .phase_ff(phase_ff),
      .strap_last_ff(strap_last_ff),
      .done_ff(scan_done_ff)
   );

   lpsc_addr_ptr #(
      .W(8)
   ) u_ptr (
      .clk(clk),
      .reset_n(reset_n),
      .load(ptr_load && !standby),
      .load_val(ptr_value),
      .step(data_strobe),
      .ptr_ff(ram_addr_ff)
   );

   // mode state and configuration
   always_comb begin
      nxt_state = state_ff;
      nxt_disp_cfg = disp_cfg_ff;
      nxt_blink = blink_ff;
      nxt_bright = brightness_ff;
      nxt_pin_cfg = shared_pin_config_ff;
      nxt_accept = cmd_ok;
      nxt_we = data_strobe && data_write && !standby;
      case (state_ff)
         lpsc_pkg::ST_STANDBY: begin
            if (key_wake || (cmd_ok && is_sys && cmd_byte[0])) begin
               nxt_state = lpsc_pkg::ST_WAKE;
            end
         end
         lpsc_pkg::ST_WAKE: begin
            if (cmd_ok && is_sys && !cmd_byte[0]) begin
               nxt_state = lpsc_pkg::ST_STANDBY;
            end else if (scan_done_ff) begin
               nxt_state = lpsc_pkg::ST_RUN;
            end
         end
         lpsc_pkg::ST_RUN: begin
            if (cmd_ok && is_sys && !cmd_byte[0]) begin
               nxt_state = lpsc_pkg::ST_STANDBY;
            end
         end
         default: nxt_state = lpsc_pkg::ST_STANDBY;
      endcase
      if (cmd_ok) begin
         case (cmd_byte & lpsc_pkg::CMD_MASK)
            lpsc_pkg::CMD_DISP: begin
               nxt_disp_cfg = cmd_byte[0];
               nxt_blink = cmd_byte[2:1];
            end
            lpsc_pkg::CMD_PIN: nxt_pin_cfg = cmd_byte[1:0];
            lpsc_pkg::CMD_DIM: nxt_bright = cmd_byte[3:0];
            default: nxt_blink = blink_ff;
         endcase
      end
   end

   // straps sampled once after reset release and at the end of each strap phase
   always_comb begin
      nxt_por_sample = 1'b0;
      nxt_slave = slave_addr_ff;
      if (por_sample_ff || strap_last_ff) begin
         // an open strap is pulled low, so all open gives the base address
         nxt_slave = lpsc_pkg::SLAVE_BASE
                   | {6'h00, anode_line_i[lpsc_pkg::STRAP1_IDX], anode_line_i[lpsc_pkg::STRAP0_IDX]};
      end
   end

   // pin roles
   always_comb begin
      int_level = shared_pin_config_ff[1] ? key_int_flag : !key_int_flag;
      nxt_cath_o = lpsc_pkg::RST_CATH_O;
      nxt_cath_oe = lpsc_pkg::RST_CATH_OE;
      nxt_an_o = '0;
      nxt_an_oe = '0;
      nxt_pd = '0;
      if (!standby) begin
         nxt_cath_o = '0;
         nxt_cath_oe = '0;
         case (phase_ff)
            lpsc_pkg::PH_STRAP: begin
               nxt_cath_o[0] = 1'b1;
               nxt_cath_oe[0] = 1'b1;
            end
            lpsc_pkg::PH_ROW0, lpsc_pkg::PH_ROW1, lpsc_pkg::PH_ROW2: begin
               nxt_cath_o[3:1] = phase_ff[3:1];
               nxt_cath_oe[3:1] = phase_ff[3:1];
               nxt_pd = key_cols;
            end
            lpsc_pkg::PH_DISP: begin
               // display is lit only once the wake-up scan is over
               if (state_ff == lpsc_pkg::ST_RUN && disp_cfg_ff) begin
                  nxt_cath_oe[disp_row] = 1'b1;
                  nxt_an_o = disp_anode;
                  nxt_an_oe = disp_anode;
               end
            end
            default: nxt_cath_oe = '0;
         endcase
      end
      if (shared_pin_config_ff[0]) begin
         // pin is the interrupt output in every state, even asleep
         nxt_an_oe[lpsc_pkg::INT_PIN_IDX] = 1'b1;
         nxt_an_o[lpsc_pkg::INT_PIN_IDX] = standby ? !shared_pin_config_ff[1] : int_level;
         nxt_pd[lpsc_pkg::INT_PIN_IDX] = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_ff <= lpsc_pkg::ST_STANDBY;
         disp_cfg_ff <= 1'b0;
         blink_ff <= lpsc_pkg::RST_BLINK;
         brightness_ff <= lpsc_pkg::RST_BRIGHT;
         shared_pin_config_ff <= lpsc_pkg::RST_PIN_CFG;
         cmd_accept_ff <= 1'b0;
         ram_we_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         disp_cfg_ff <= nxt_disp_cfg;
         blink_ff <= nxt_blink;
         brightness_ff <= nxt_bright;
         shared_pin_config_ff <= nxt_pin_cfg;
         cmd_accept_ff <= nxt_accept;
         ram_we_ff <= nxt_we;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         por_sample_ff <= 1'b1;
         slave_addr_ff <= lpsc_pkg::SLAVE_BASE;
      end else begin
         por_sample_ff <= nxt_por_sample;
         slave_addr_ff <= nxt_slave;
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         osc_run_ff <= 1'b0;
         display_on_ff <= 1'b0;
         key_scan_run_ff <= 1'b0;
         key_clear_ff <= 1'b1;
         cathode_line_o_ff <= lpsc_pkg::RST_CATH_O;
         cathode_line_oe_ff <= lpsc_pkg::RST_CATH_OE;
         anode_line_o_ff <= '0;
         anode_line_oe_ff <= '0;
         anode_pulldown_ff <= '0;
      end else begin
         osc_run_ff <= !standby;
         display_on_ff <= (state_ff == lpsc_pkg::ST_RUN) && disp_cfg_ff;
         key_scan_run_ff <= !standby;
         key_clear_ff <= standby;
         cathode_line_o_ff <= nxt_cath_o;
         cathode_line_oe_ff <= nxt_cath_oe;
         anode_line_o_ff <= nxt_an_o;
         anode_line_oe_ff <= nxt_an_oe;
         anode_pulldown_ff <= nxt_pd;
      end
   end

   a_standby_pins: assert property (@(posedge clk) disable iff (!reset_n)
      standby |=> cathode_line_oe_ff == 8'h0f && cathode_line_o_ff == 8'h0f && !osc_run_ff && !display_on_ff)
      else $error("standby cathode pattern or run flags wrong");
   a_standby_ignore: assert property (@(posedge clk) disable iff (!reset_n)
      standby && cmd_valid && !is_sys |=> !cmd_accept_ff && $stable(brightness_ff) && $stable(shared_pin_config_ff))
      else $error("command accepted in standby");
   a_sys_sleep: assert property (@(posedge clk) disable iff (!reset_n)
      cmd_valid && is_sys && !cmd_byte[0] |=> state_ff == lpsc_pkg::ST_STANDBY ##1 key_clear_ff)
      else $error("system set bit0 low did not enter standby");
   a_key_clear: assert property (@(posedge clk) disable iff (!reset_n)
      standby ##1 standby |-> key_clear_ff)
      else $error("key data not held cleared in standby");
   a_wake_key: assert property (@(posedge clk) disable iff (!reset_n)
      standby && key_wake |=> state_ff == lpsc_pkg::ST_WAKE ##1 osc_run_ff && key_scan_run_ff)
      else $error("key press did not wake device");
   a_anode_inputs: assert property (@(posedge clk) disable iff (!reset_n)
      standby |=> anode_line_oe_ff == (shared_pin_config_ff[0] ? 12'h800 : 12'h000))
      else $error("anode lines driven in standby");
   a_int_idle: assert property (@(posedge clk) disable iff (!reset_n)
      standby && shared_pin_config_ff[0] |=> anode_line_o_ff[11] == !$past(shared_pin_config_ff[1]))
      else $error("interrupt pin not at inactive level in standby");
   a_wake_display: assert property (@(posedge clk) disable iff (!reset_n)
      state_ff == lpsc_pkg::ST_WAKE |=> !display_on_ff)
      else $error("display lit before wake-up scan finished");
   a_strap_addr: assert property (@(posedge clk) disable iff (!reset_n)
      strap_last_ff |=> slave_addr_ff == (8'he0 | {6'h00, $past(anode_line_i[0]), $past(anode_line_i[1])}))
      else $error("slave address not taken from straps");
   a_row_pull: assert property (@(posedge clk) disable iff (!reset_n)
      !standby && phase_ff == lpsc_pkg::PH_ROW1 |=> cathode_line_o_ff[2] && anode_pulldown_ff[10:2] == 9'h1ff)
      else $error("key row drive or pull-down missing");
   a_ptr_step: assert property (@(posedge clk) disable iff (!reset_n)
      data_strobe && !ptr_load |=> ram_addr_ff == 8'($past(ram_addr_ff) + 8'h01))
      else $error("address pointer did not advance");
   // pins are registered, so each check looks one edge after the state that drives them
   a_sys_accept: assert property (@(posedge clk) disable iff (!reset_n)
      standby && cmd_valid && is_sys |=> cmd_accept_ff)
      else $error("system set command refused in standby");
   a_we_standby: assert property (@(posedge clk) disable iff (!reset_n)
      standby |=> !ram_we_ff)
      else $error("display memory write allowed in standby");
   a_wake_cmd: assert property (@(posedge clk) disable iff (!reset_n)
      standby && cmd_valid && is_sys && cmd_byte[0] |=> state_ff == lpsc_pkg::ST_WAKE)
      else $error("system set bit0 high did not wake device");
   a_wake_scan: assert property (@(posedge clk) disable iff (!reset_n)
      state_ff == lpsc_pkg::ST_WAKE |=> key_scan_run_ff && osc_run_ff && !key_clear_ff)
      else $error("key scan not running after wake-up");
   a_disp_follow: assert property (@(posedge clk) disable iff (!reset_n)
      state_ff == lpsc_pkg::ST_RUN && disp_cfg_ff |=> display_on_ff)
      else $error("display not restored from stored setting");
   a_int_out: assert property (@(posedge clk) disable iff (!reset_n)
      shared_pin_config_ff[0] |=> anode_line_oe_ff[11] && !anode_pulldown_ff[11])
      else $error("shared pin not driven as interrupt output");
   a_int_polarity: assert property (@(posedge clk) disable iff (!reset_n)
      !standby && shared_pin_config_ff[0]
      |=> anode_line_o_ff[11] == ($past(shared_pin_config_ff[1]) ? $past(key_int_flag) : !$past(key_int_flag)))
      else $error("interrupt level does not follow polarity");
   a_por_sample: assert property (@(posedge clk) disable iff (!reset_n)
      por_sample_ff |=> slave_addr_ff == (8'he0 | {6'h00, $past(anode_line_i[0]), $past(anode_line_i[1])}))
      else $error("slave address not taken from straps after reset");
   a_addr_hold: assert property (@(posedge clk) disable iff (!reset_n)
      !por_sample_ff && !strap_last_ff |=> $stable(slave_addr_ff))
      else $error("slave address changed outside strap sampling");
   a_strap_drive: assert property (@(posedge clk) disable iff (!reset_n)
      !standby && phase_ff == lpsc_pkg::PH_STRAP |=> cathode_line_o_ff[3:0] == 4'h1 && cathode_line_oe_ff[0])
      else $error("strap source not driven during strap phase");
   a_row0_drive: assert property (@(posedge clk) disable iff (!reset_n)
      !standby && phase_ff == lpsc_pkg::PH_ROW0 |=> cathode_line_o_ff[3:1] == 3'h1 && cathode_line_oe_ff[3:1] == 3'h1)
      else $error("first key row not driven");
endmodule // lpsc_power_ctrl

// File: lpsc_scan_seq.sv
// key-scan phase sequencer: strap, three rows, then display time
`timescale 1ns/1ps
module lpsc_scan_seq #(
   parameter int STEP_CYC = lpsc_pkg::SCAN_STEP_CYC,
   parameter int CYCLE_CYC = lpsc_pkg::SCAN_CYCLE_CYC
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic run,
   output lpsc_pkg::lpsc_phase_t phase_ff,
   output logic strap_last_ff,
   output logic done_ff
);
   localparam int DISP_CYC = (CYCLE_CYC > 4 * STEP_CYC) ? CYCLE_CYC - 4 * STEP_CYC : 1;
   logic [31:0] cnt_ff;
   logic [31:0] nxt_cnt;
   lpsc_pkg::lpsc_phase_t nxt_phase;
   logic nxt_strap_last;
   logic nxt_done;
   logic [31:0] limit;

   always_comb begin
      limit = (phase_ff == lpsc_pkg::PH_DISP) ? 32'(DISP_CYC - 1) : 32'(STEP_CYC - 1);
      nxt_cnt = cnt_ff + 32'h1;
      nxt_phase = phase_ff;
      nxt_strap_last = 1'b0;
      nxt_done = 1'b0;
      if (!run) begin
         nxt_cnt = '0;
         nxt_phase = lpsc_pkg::PH_STRAP;
      end else if (cnt_ff >= limit) begin
         nxt_cnt = '0;
         case (phase_ff)
            lpsc_pkg::PH_STRAP: begin
               nxt_phase = lpsc_pkg::PH_ROW0;
               nxt_strap_last = 1'b1;
            end
            lpsc_pkg::PH_ROW0: nxt_phase = lpsc_pkg::PH_ROW1;
            lpsc_pkg::PH_ROW1: nxt_phase = lpsc_pkg::PH_ROW2;
            lpsc_pkg::PH_ROW2: begin
               nxt_phase = lpsc_pkg::PH_DISP;
               nxt_done = 1'b1;
            end
            default: nxt_phase = lpsc_pkg::PH_STRAP;
         endcase
      end
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt_ff <= '0;
         phase_ff <= lpsc_pkg::PH_STRAP;
         strap_last_ff <= 1'b0;
         done_ff <= 1'b0;
      end else begin
         cnt_ff <= nxt_cnt;
         phase_ff <= nxt_phase;
         strap_last_ff <= nxt_strap_last;
         done_ff <= nxt_done;
      end
   end
endmodule // lpsc_scan_seq

// File: tb_led_driver_power_standby_ctrl.sv
// self-checking testbench of the power, standby and wake-up control
`timescale 1ns/1ps
module tb_led_driver_power_standby_ctrl;
   logic clk, reset_n, cmd_valid, ptr_load, data_strobe, data_write, key_wake, key_int_flag;
   logic [7:0] cmd_byte, ptr_value, slave_addr_ff, ram_addr_ff, cathode_line_o_ff, cathode_line_oe_ff;
   logic [11:0] disp_anode, anode_line_i, anode_line_o_ff, anode_line_oe_ff, anode_pulldown_ff;
   logic [2:0] disp_row;
   logic osc_run_ff, display_on_ff, key_scan_run_ff, key_clear_ff, cmd_accept_ff, ram_we_ff;
   logic [1:0] blink_ff, shared_pin_config_ff, exp_blink, exp_cfg, straps;
   logic [3:0] brightness_ff, exp_bright;
   logic [7:0] exp_addr;
   logic [31:0] rng_state = 32'h2b29;
   logic [31:0] r;
   logic in_sb;
   int fails = 0;
   int check_count = 0;
   int i;
   string note_name[$];
   string n_name;
   logic [7:0] note_val[$];
   logic [7:0] n_val;

   lpsc_power_ctrl #(.STEP_CYC(4), .CYCLE_CYC(32)) u_lpsc_power_ctrl (.clk(clk), .reset_n(reset_n),
      .cmd_valid(cmd_valid), .cmd_byte(cmd_byte), .ptr_load(ptr_load), .ptr_value(ptr_value),
      .data_strobe(data_strobe), .data_write(data_write), .key_wake(key_wake), .key_int_flag(key_int_flag),
      .disp_anode(disp_anode), .disp_row(disp_row), .anode_line_i(anode_line_i), .osc_run_ff(osc_run_ff),
      .display_on_ff(display_on_ff), .key_scan_run_ff(key_scan_run_ff), .key_clear_ff(key_clear_ff),
      .blink_ff(blink_ff), .brightness_ff(brightness_ff), .shared_pin_config_ff(shared_pin_config_ff),
      .slave_addr_ff(slave_addr_ff), .cmd_accept_ff(cmd_accept_ff), .ram_we_ff(ram_we_ff),
      .ram_addr_ff(ram_addr_ff), .cathode_line_o_ff(cathode_line_o_ff), .cathode_line_oe_ff(cathode_line_oe_ff),
      .anode_line_o_ff(anode_line_o_ff), .anode_line_oe_ff(anode_line_oe_ff),
      .anode_pulldown_ff(anode_pulldown_ff));

   lpsc_host_model #(.QUIET_CYC(20)) u_lpsc_host_model (.clk(clk), .reset_n(reset_n), .cmd_valid(cmd_valid),
      .cmd_byte(cmd_byte), .ptr_load(ptr_load), .ptr_value(ptr_value), .data_strobe(data_strobe),
      .data_write(data_write));

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   function automatic logic [31:0] nxt_rand();
      rng_state ^= rng_state << 13;
      rng_state ^= rng_state >> 17;
      rng_state ^= rng_state << 5;
      return rng_state;
   endfunction

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic close_out();
      chk("pending results", 32'h0, note_val.size());
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask

   // accepted commands carry a settings snapshot, ram writes the pointer after the step
   always @(posedge clk) begin
      #2;
      if (cmd_accept_ff === 1'b1 || ram_we_ff === 1'b1) begin
         if (note_val.size() == 0) begin
            chk("unexpected result", 32'h0, 32'h1);
         end else begin
            n_name = note_name.pop_front();
            n_val = note_val.pop_front();
            chk(n_name, n_val, cmd_accept_ff ? {blink_ff, shared_pin_config_ff, brightness_ff} : ram_addr_ff);
         end
      end
   end

   task automatic cmd(input logic [7:0] b);
      if (!in_sb || (b & lpsc_pkg::CMD_MASK) == lpsc_pkg::CMD_SYS) begin
         case (b & lpsc_pkg::CMD_MASK)
            lpsc_pkg::CMD_DISP: exp_blink = b[2:1];
            lpsc_pkg::CMD_PIN: exp_cfg = b[1:0];
            lpsc_pkg::CMD_DIM: exp_bright = b[3:0];
            lpsc_pkg::CMD_SYS: in_sb = !b[0];
            default: ;
         endcase
         note_name.push_back("settings");
         note_val.push_back({exp_blink, exp_cfg, exp_bright});
      end
      u_lpsc_host_model.xfer(0, b);
   endtask

   task automatic data(input logic w);
      // pointer steps even in standby, only the write itself is refused
      exp_addr = exp_addr + 8'h01;
      if (w && !in_sb) begin
         note_name.push_back("ram address");
         note_val.push_back(exp_addr);
      end
      u_lpsc_host_model.xfer(2, {7'h00, w});
   endtask

   task automatic check_sb();
      chk("power flags", 4'b0001, {osc_run_ff, display_on_ff, key_scan_run_ff, key_clear_ff});
      chk("cathode drive", {lpsc_pkg::RST_CATH_O, lpsc_pkg::RST_CATH_OE}, {cathode_line_o_ff, cathode_line_oe_ff});
      chk("anode enables", {exp_cfg[0], 23'h0}, {anode_line_oe_ff, anode_pulldown_ff});
      if (exp_cfg[0]) chk("int idle level", !exp_cfg[1], anode_line_o_ff[11]);
   endtask

   task automatic do_reset();
      #1;
      reset_n = 1'b0;
      in_sb = 1'b1;
      exp_blink = lpsc_pkg::RST_BLINK;
      exp_cfg = lpsc_pkg::RST_PIN_CFG;
      exp_bright = lpsc_pkg::RST_BRIGHT;
      exp_addr = 8'h00;
      anode_line_i = 12'h000;
      repeat (20) @(posedge clk);
      #1;
      check_sb();
      chk("reset settings", {exp_blink, exp_cfg, exp_bright}, {blink_ff, shared_pin_config_ff, brightness_ff});
      reset_n = 1'b1;
      @(posedge clk);
      #1;
      chk("floating strap address", lpsc_pkg::SLAVE_BASE, slave_addr_ff);
      $display("test reset done");
   endtask

   initial begin
      reset_n = 1'b0;
      key_wake = 1'b0;
      key_int_flag = 1'b0;
      disp_anode = 12'h000;
      disp_row = 3'h0;
      anode_line_i = 12'h000;
      do_reset();
      cmd(8'h81);
      cmd(8'ha1);
      cmd(8'he3);
      u_lpsc_host_model.xfer(1, 8'h10);
      data(1'b1);
      chk("refused pointer", exp_addr, ram_addr_ff);
      $display("test standby refusal done");
      r = nxt_rand();
      straps = r[1:0];
      anode_line_i = {r[11:2], straps[0], straps[1]};
      cmd(8'h21);
      chk("wake flags", 4'b1010, {osc_run_ff, display_on_ff, key_scan_run_ff, key_clear_ff});
      chk("strap source", 1'b1, cathode_line_o_ff[0]);
      i = 0;
      while (cathode_line_o_ff[1] !== 1'b1 && i < 20) begin
         @(posedge clk);
         #1;
         i++;
      end
      chk("row drive", 3'b001, cathode_line_o_ff[3:1]);
      chk("key pull-downs", 9'h1ff, anode_pulldown_ff[10:2]);
      chk("strap address", lpsc_pkg::SLAVE_BASE | {6'h0, straps}, slave_addr_ff);
      u_lpsc_host_model.xfer(1, 8'hfe);
      exp_addr = 8'hfe;
      data(1'b1);
      data(1'b1);
      data(1'b0);
      chk("pointer after read", 8'h01, ram_addr_ff);
      cmd(8'h83);
      r = nxt_rand();
      cmd(lpsc_pkg::CMD_DIM | {4'h0, r[3:0]});
      $display("test wake and data done");
      for (int k = 0; k < 4; k++) begin
         r = nxt_rand();
         key_int_flag = r[0];
         disp_anode = r[23:12];
         disp_row = r[26:24];
         cmd(lpsc_pkg::CMD_PIN | 8'(k));
         if (k[0]) chk("int pin", {1'b1, r[0] ~^ k[1]}, {anode_line_oe_ff[11], anode_line_o_ff[11]});
         cmd(8'h20);
         check_sb();
         anode_line_i[1:0] = ~anode_line_i[1:0];
         repeat (3) @(posedge clk);
         #1;
         chk("address held in standby", lpsc_pkg::SLAVE_BASE | {6'h0, straps}, slave_addr_ff);
         straps = ~straps;
         if (k[0]) begin
            key_wake = 1'b1;
            i = 0;
            while (osc_run_ff !== 1'b1 && i < 5) begin
               @(posedge clk);
               #1;
               i++;
            end
            key_wake = 1'b0;
            in_sb = 1'b0;
            chk("key wake", 1'b1, osc_run_ff);
         end else begin
            cmd(8'h21);
         end
         i = 0;
         while (display_on_ff !== 1'b1 && i < 80) begin
            @(posedge clk);
            #1;
            i++;
         end
         chk("display restored", 3'b101, {display_on_ff, blink_ff});
         chk("display pins", {disp_anode[10:0], 8'h01 << disp_row}, {anode_line_o_ff[10:0], cathode_line_oe_ff});
      end
      $display("test standby cycles done");
      do_reset();
      close_out();
   end

   initial begin
      #(5000 * 10);
      fails++;
      close_out();
   end
endmodule // tb_led_driver_power_standby_ctrl
